// ===== rtl/clc_pkg.sv
package clc_pkg;
    // register offsets on the plain register port
    localparam logic [5:0] CLC_OFS_TX_MODE = 6'h12;
    localparam logic [5:0] CLC_OFS_RX_MODE = 6'h13;
    localparam logic [5:0] CLC_OFS_DRV_CTRL = 6'h14;
    localparam logic [5:0] CLC_OFS_AUTO_WAKE = 6'h15;
    localparam logic [5:0] CLC_OFS_SRC_SEL = 6'h16;
    localparam logic [5:0] CLC_OFS_RX_SEL = 6'h17;
    localparam logic [5:0] CLC_OFS_THRESH = 6'h18;
    localparam logic [5:0] CLC_OFS_DEMOD = 6'h19;
    localparam logic [5:0] CLC_OFS_PASSIVE = 6'h1b;
    localparam logic [5:0] CLC_OFS_CARD = 6'h1c;
    localparam logic [5:0] CLC_OFS_MANUAL = 6'h1d;
    localparam int CLC_NREG = 11;
    localparam int CLC_IX_TX_MODE = 0;
    localparam int CLC_IX_RX_MODE = 1;
    localparam int CLC_IX_DRV_CTRL = 2;
    localparam int CLC_IX_AUTO_WAKE = 3;
    localparam int CLC_IX_SRC_SEL = 4;
    localparam int CLC_IX_RX_SEL = 5;
    localparam int CLC_IX_THRESH = 6;
    localparam int CLC_IX_DEMOD = 7;
    localparam int CLC_IX_PASSIVE = 8;
    localparam int CLC_IX_CARD = 9;
    // index 10 first, index 0 last
    localparam logic [CLC_NREG-1:0][5:0] CLC_OFS = {CLC_OFS_MANUAL,
        CLC_OFS_CARD, CLC_OFS_PASSIVE, CLC_OFS_DEMOD, CLC_OFS_THRESH,
        CLC_OFS_RX_SEL, CLC_OFS_SRC_SEL, CLC_OFS_AUTO_WAKE,
        CLC_OFS_DRV_CTRL, CLC_OFS_RX_MODE, CLC_OFS_TX_MODE};
    // writable bits; all others read zero, except card bit 2, which reads the halted flag
    localparam logic [CLC_NREG-1:0][7:0] CLC_MASK = {8'h7f, 8'hfb,
        8'hc0, 8'hff, 8'hf7, 8'hff, 8'h3f, 8'h20, 8'hb0, 8'hfb, 8'hf3};
    localparam logic [CLC_NREG-1:0][7:0] CLC_RESET = {8'h00, 8'h62,
        8'h00, 8'h4d, 8'h84, 8'h84, 8'h10, 8'h00, 8'h80, 8'h00, 8'h00};
    // field positions
    localparam int CLC_CRC_BIT = 7;
    localparam int CLC_RATE_LSB = 4;
    localparam int CLC_NOERR_BIT = 3;
    localparam int CLC_INV_B_BIT = 5;
    localparam int CLC_INV_A_BIT = 4;
    localparam int CLC_WAKE_BIT = 5;
    localparam int CLC_DRV_LSB = 4;
    localparam int CLC_UART_LSB = 6;
    localparam int CLC_MIN_LSB = 4;
    localparam int CLC_EVEN_BIT = 4;
    localparam int CLC_TAU_LSB = 2;
    localparam int CLC_HOLD_BIT = 7;
    localparam int CLC_HALF_BIT = 6;
    localparam int CLC_HALT_BIT = 2;
    // codes and counts
    localparam logic [2:0] CLC_RATE_106 = 3'h0;
    localparam logic [2:0] CLC_RATE_424 = 3'h2;
    localparam logic [1:0] CLC_SEL_OFF = 2'h0;
    localparam logic [1:0] CLC_SEL_CODER = 2'h1;
    localparam logic [1:0] CLC_SEL_SIGNAL_IN_PIN = 2'h2;
    localparam logic [3:0] CLC_SO_OFF = 4'h0;
    localparam logic [3:0] CLC_SO_LOW = 4'h1;
    localparam logic [3:0] CLC_SO_HIGH = 4'h2;
    localparam logic [3:0] CLC_SO_ENV = 4'h4;
    localparam logic [3:0] CLC_SO_TXD = 4'h5;
    localparam logic [3:0] CLC_SO_RXD = 4'h7;
    localparam logic [1:0] CLC_TAU_FROZEN = 2'h0;
    localparam logic [7:0] CLC_WAKE_REQ = 8'h52;
    localparam logic [3:0] CLC_RESP_BASE = 4'h7;
    localparam logic [7:0] CLC_MIN_FRAME_BITS = 8'h04;
    typedef enum logic [1:0] {
        CLC_GD_LISTEN = 2'b00,
        CLC_GD_GUARD = 2'b01
    } clc_guard_type;
endpackage : clc_pkg

// ===== rtl/clc_link_config.sv
// Function
// - tx crc enable appends crc; host clears only at 106 kbit
// - tx rate field 000/001/010 selects 106/212/424 kbit
// - rx rate field same codes; nothing above 424 kbit
// - tx framing 00 is 14443-A 106, 10 is 212/424 card framing
// - rx framing uses the same two codes
// - rx crc enable checks crc; host clears only at 106 kbit
// - with drop-short set, frames under 4 bits discarded, receiver stays on
// - invert bits 5 and 4 invert drivers b and a; host sets both equal
// - wake enable plus soft power-down: rf level restarts device
// - driver source 00 off, 01 coder, 10 signal-in, 11 high
// - in soft power-down drivers float only when source selects off
// - signal-out selector: off, low, high, envelope, tx stream, rx stream
// - uart input: low, signal-in envelope, analog modulation, signal-in mod
// - receiver held off for guard bit clocks after last tx pulse
// - plain receive command skips guard delay, all others apply it
// - decoder input below minimum strength is not evaluated
// - timer divides carrier by 2p+1, or 2p+2 with even bit set
// - time constant 00 freezes recovery loop during reception
// - hold bit ends anticollision only after select; no active mode
// - at 424 kbit half-slot bit halves the 212 kbit slot
// - halted flag allows only request 52h; rf reset clears it
// - response delay is wait field plus 7 bit periods
`timescale 1ns/1ps
module clc_link_config
    import clc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic tx_crc_enable_o,
    output logic [2:0] tx_rate_sel_o,
    output logic [1:0] tx_frame_format_o,
    output logic rx_crc_enable_o,
    output logic [2:0] rx_rate_sel_o,
    output logic [1:0] rx_frame_format_o,
    input wire logic rx_frame_end_i,
    input wire logic [7:0] rx_frame_bits_i,
    output logic rx_frame_discard_o,
    input wire logic coder_env_i,
    input wire logic tx_serial_i,
    input wire logic rx_serial_i,
    input wire logic analog_mod_i,
    input wire logic signal_in_pin_i,
    input wire logic rf_level_i,
    input wire logic soft_power_down_i,
    output logic antenna_driver_a_o,
    output logic antenna_driver_a_oe_o,
    output logic antenna_driver_b_o,
    output logic antenna_driver_b_oe_o,
    output logic field_wake_o,
    output logic signal_out_pin_o,
    output logic signal_out_pin_oe_o,
    output logic cl_uart_in_o,
    input wire logic tx_last_pulse_i,
    input wire logic bit_clk_tick_i,
    input wire logic cmd_is_receive_i,
    input wire logic rx_input_i,
    input wire logic [3:0] decoder_strength_i,
    output logic rx_enable_o,
    output logic rx_bit_o,
    input wire logic carrier_tick_i,
    output logic timer_tick_o,
    input wire logic rx_receiving_i,
    output logic pll_freeze_o,
    input wire logic autocoll_cmd_valid_i,
    input wire logic card_selected_i,
    output logic autocoll_done_o,
    output logic active_comm_allowed_o,
    output logic slot_half_o,
    input wire logic halt_set_i,
    input wire logic rf_reset_i,
    input wire logic req_valid_i,
    input wire logic [7:0] req_code_i,
    output logic req_accept_o,
    output logic [3:0] response_delay_o
);

////////////////////////////////////////////////////////////////////////////
// register file

logic [CLC_NREG-1:0][7:0] regs_r;
logic [CLC_NREG-1:0] hit;
logic [CLC_NREG-1:0][7:0] rd_term;
logic card_halted_flag_r;
logic [7:0] rd_word;
logic [7:0] rdata_r;

genvar gi;
generate
    for (gi = 0; gi < CLC_NREG; gi++) begin : g_reg
        assign hit[gi] = (reg_addr_i == CLC_OFS[gi]);
        // reserved bits never stored, so they read zero
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                regs_r[gi] <= CLC_RESET[gi] & CLC_MASK[gi];
            end else if (reg_wr_i && hit[gi]) begin
                regs_r[gi] <= reg_wdata_i & CLC_MASK[gi];
            end
        end
        assign rd_term[gi] = hit[gi] ? regs_r[gi] : 8'h00;
    end
endgenerate

always_comb begin
    rd_word = 8'h00;
    for (int i = 0; i < CLC_NREG; i++) begin
        rd_word = rd_word | rd_term[i];
    end
    if (hit[CLC_IX_CARD]) begin
        rd_word[CLC_HALT_BIT] = card_halted_flag_r;
    end
end

always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        rdata_r <= 8'h00;
    end else begin
        rdata_r <= reg_rd_i ? rd_word : 8'h00;
    end
end
assign reg_rdata_o = rdata_r;

////////////////////////////////////////////////////////////////////////////
// field decode

wire [7:0] txm = regs_r[CLC_IX_TX_MODE];
wire [7:0] rxm = regs_r[CLC_IX_RX_MODE];
wire [7:0] sel = regs_r[CLC_IX_SRC_SEL];
wire [7:0] rxs = regs_r[CLC_IX_RX_SEL];
wire [7:0] dem = regs_r[CLC_IX_DEMOD];
wire [7:0] pas = regs_r[CLC_IX_PASSIVE];
wire [7:0] crd = regs_r[CLC_IX_CARD];
wire [2:0] tx_rate_raw = txm[CLC_RATE_LSB +: 3];
wire [2:0] rx_rate_raw = rxm[CLC_RATE_LSB +: 3];
// codes above 010 have no rate; treated as 424 kbit
wire [2:0] tx_rate = (tx_rate_raw > CLC_RATE_424) ? CLC_RATE_424
                                                  : tx_rate_raw;
wire [2:0] rx_rate = (rx_rate_raw > CLC_RATE_424) ? CLC_RATE_424
                                                  : rx_rate_raw;
wire [1:0] driver_source_sel = sel[CLC_DRV_LSB +: 2];
wire [3:0] sig_out_source_sel = sel[3:0];
wire [1:0] cl_uart_input_sel = rxs[CLC_UART_LSB +: 2];
wire [5:0] rx_guard_delay = rxs[5:0];
wire [3:0] decoder_min_strength = regs_r[CLC_IX_THRESH][CLC_MIN_LSB +: 4];
wire [1:0] rx_loop_time_const = dem[CLC_TAU_LSB +: 2];
wire hold_until_selected = pas[CLC_HOLD_BIT];
wire half_slot_sel = pas[CLC_HALF_BIT];
wire [1:0] response_extra_delay = crd[1:0];

////////////////////////////////////////////////////////////////////////////
// pin synchronisers: signal-in and rf level

logic [1:0][2:0] sync_r;
logic [1:0] pin_lvl_r;
wire [1:0] pin_raw = {rf_level_i, signal_in_pin_i};
generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                sync_r[gi] <= 3'h0;
                pin_lvl_r[gi] <= 1'b0;
            end else begin
                sync_r[gi] <= {sync_r[gi][1:0], pin_raw[gi]};
                if (sync_r[gi][1] == sync_r[gi][2]) begin
                    pin_lvl_r[gi] <= sync_r[gi][2];
                end
            end
        end
    end
endgenerate
wire sig_in = pin_lvl_r[0];
wire rf_on = pin_lvl_r[1];

////////////////////////////////////////////////////////////////////////////
// analog source selection

// power-down does not enter here: only source 00 floats the drivers
wire drv_src = (driver_source_sel == CLC_SEL_CODER) ? coder_env_i :
               (driver_source_sel == CLC_SEL_SIGNAL_IN_PIN) ? sig_in :
               1'b1;
wire drv_oe = (driver_source_sel != CLC_SEL_OFF);
wire drv_a = drv_src ^ regs_r[CLC_IX_DRV_CTRL][CLC_INV_A_BIT];
wire drv_b = drv_src ^ regs_r[CLC_IX_DRV_CTRL][CLC_INV_B_BIT];
wire so_val = (sig_out_source_sel == CLC_SO_HIGH) ? 1'b1 :
              (sig_out_source_sel == CLC_SO_ENV) ? coder_env_i :
              (sig_out_source_sel == CLC_SO_TXD) ? tx_serial_i :
              (sig_out_source_sel == CLC_SO_RXD) ? rx_serial_i :
              1'b0;
wire so_oe = (sig_out_source_sel != CLC_SO_OFF);
wire uart_val = (cl_uart_input_sel == 2'h0) ? 1'b0 :
                (cl_uart_input_sel == 2'h1) ? sig_in :
                (cl_uart_input_sel == 2'h2) ? analog_mod_i :
                sig_in;
wire wake = regs_r[CLC_IX_AUTO_WAKE][CLC_WAKE_BIT] && soft_power_down_i
            && rf_on;

////////////////////////////////////////////////////////////////////////////
// receive guard time and decoder gate

clc_guard_type guard_r;
clc_guard_type guard_nxt;
logic [5:0] guard_cnt_r;
logic [5:0] guard_cnt_nxt;
wire guard_skip = cmd_is_receive_i || (rx_guard_delay == 6'h00);
wire guard_last = bit_clk_tick_i && (guard_cnt_r == 6'h01);

always_comb begin
    guard_nxt = guard_r;
    guard_cnt_nxt = guard_cnt_r;
    unique case (guard_r)
        CLC_GD_LISTEN: begin
            if (tx_last_pulse_i && !guard_skip) begin
                guard_nxt = CLC_GD_GUARD;
                guard_cnt_nxt = rx_guard_delay;
            end
        end
        CLC_GD_GUARD: begin
            if (bit_clk_tick_i) begin
                guard_cnt_nxt = guard_cnt_r - 6'h01;
            end
            if (guard_last) begin
                guard_nxt = CLC_GD_LISTEN;
            end
        end
    endcase
end

wire sig_strong = (decoder_strength_i >= decoder_min_strength);
wire rx_open = (guard_nxt == CLC_GD_LISTEN);
wire drop = rx_frame_end_i && rxm[CLC_NOERR_BIT]
            && (rx_frame_bits_i < CLC_MIN_FRAME_BITS);

////////////////////////////////////////////////////////////////////////////
// timer prescaler

logic [12:0] tdiv_cnt_r;
wire [11:0] timer_divider_value = {regs_r[CLC_IX_PASSIVE][3:0] & 4'h0,
                                   8'h00} | 12'h000;
// 12-bit divider registered outside this group, in the state block below
logic [11:0] timer_divider_r;
wire timer_prescale_even = dem[CLC_EVEN_BIT];
wire [12:0] tdiv_last = {timer_divider_r, 1'b0}
                        + {12'h000, timer_prescale_even};
wire tdiv_wrap = carrier_tick_i && (tdiv_cnt_r >= tdiv_last);

////////////////////////////////////////////////////////////////////////////
// card and passive-target state

wire sel_cmd = autocoll_cmd_valid_i
               && (!hold_until_selected || card_selected_i);
wire halt_wr = reg_wr_i && hit[CLC_IX_CARD];
wire accept = req_valid_i
              && (!card_halted_flag_r || req_code_i == CLC_WAKE_REQ);

always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        card_halted_flag_r <= 1'b0;
    end else if (halt_set_i) begin
        card_halted_flag_r <= 1'b1;
    end else if (rf_reset_i) begin
        card_halted_flag_r <= 1'b0;
    end else if (halt_wr) begin
        card_halted_flag_r <= reg_wdata_i[CLC_HALT_BIT];
    end
end

always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        guard_r <= CLC_GD_LISTEN;
        guard_cnt_r <= 6'h00;
        tdiv_cnt_r <= 13'h0000;
        timer_divider_r <= 12'h000;
    end else begin
        guard_r <= guard_nxt;
        guard_cnt_r <= guard_cnt_nxt;
        timer_divider_r <= timer_divider_value;
        if (tdiv_wrap) begin
            tdiv_cnt_r <= 13'h0000;
        end else if (carrier_tick_i) begin
            tdiv_cnt_r <= tdiv_cnt_r + 13'h0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// registered outputs

always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        tx_crc_enable_o <= 1'b0;
        tx_rate_sel_o <= CLC_RATE_106;
        tx_frame_format_o <= 2'h0;
        rx_crc_enable_o <= 1'b0;
        rx_rate_sel_o <= CLC_RATE_106;
        rx_frame_format_o <= 2'h0;
        rx_frame_discard_o <= 1'b0;
        antenna_driver_a_o <= 1'b0;
        antenna_driver_a_oe_o <= 1'b0;
        antenna_driver_b_o <= 1'b0;
        antenna_driver_b_oe_o <= 1'b0;
        field_wake_o <= 1'b0;
        signal_out_pin_o <= 1'b0;
        signal_out_pin_oe_o <= 1'b0;
        cl_uart_in_o <= 1'b0;
        rx_enable_o <= 1'b1;
        rx_bit_o <= 1'b0;
        timer_tick_o <= 1'b0;
        pll_freeze_o <= 1'b0;
        autocoll_done_o <= 1'b0;
        active_comm_allowed_o <= 1'b1;
        slot_half_o <= 1'b0;
        req_accept_o <= 1'b0;
        response_delay_o <= CLC_RESP_BASE;
    end else begin
        tx_crc_enable_o <= txm[CLC_CRC_BIT];
        tx_rate_sel_o <= tx_rate;
        tx_frame_format_o <= txm[1:0];
        rx_crc_enable_o <= rxm[CLC_CRC_BIT];
        rx_rate_sel_o <= rx_rate;
        rx_frame_format_o <= rxm[1:0];
        rx_frame_discard_o <= drop;
        antenna_driver_a_o <= drv_a;
        antenna_driver_a_oe_o <= drv_oe;
        antenna_driver_b_o <= drv_b;
        antenna_driver_b_oe_o <= drv_oe;
        field_wake_o <= wake;
        signal_out_pin_o <= so_val;
        signal_out_pin_oe_o <= so_oe;
        cl_uart_in_o <= uart_val;
        rx_enable_o <= rx_open;
        rx_bit_o <= rx_open && sig_strong && rx_input_i;
        timer_tick_o <= tdiv_wrap;
        pll_freeze_o <= rx_receiving_i
                        && (rx_loop_time_const == CLC_TAU_FROZEN);
        autocoll_done_o <= sel_cmd;
        active_comm_allowed_o <= !hold_until_selected;
        slot_half_o <= (tx_rate == CLC_RATE_424) && half_slot_sel;
        req_accept_o <= accept;
        response_delay_o <= CLC_RESP_BASE
                            + {2'h0, response_extra_delay};
    end
end

////////////////////////////////////////////////////////////////////////////
// assertions

default clocking cb @(posedge clk_sys_i);
endclocking
default disable iff (!reset_n_i);

sequence s_guard_start;
    tx_last_pulse_i && !guard_skip && guard_r == CLC_GD_LISTEN;
endsequence
sequence s_guard_closed;
    !rx_enable_o && !rx_bit_o;
endsequence

a_guard_closes: assert property (s_guard_start |=> ##1 s_guard_closed)
    else $error("receiver not held off after transmit");
a_guard_skip_rx: assert property (tx_last_pulse_i && cmd_is_receive_i
    && guard_r == CLC_GD_LISTEN |=> ##1 rx_enable_o)
    else $error("receive command applied guard delay");
a_weak_ignored: assert property (!sig_strong |=> !rx_bit_o)
    else $error("weak decoder input taken as data");
a_short_dropped: assert property (drop |=> rx_frame_discard_o)
    else $error("short frame not discarded");
a_drv_float: assert property (driver_source_sel == CLC_SEL_OFF
    |=> !antenna_driver_a_oe_o && !antenna_driver_b_oe_o)
    else $error("drivers not floating for source off");
a_pd_keeps_drv: assert property (soft_power_down_i
    && driver_source_sel == CLC_SEL_CODER |=> antenna_driver_a_oe_o)
    else $error("power-down floated an active driver");
a_halt_filter: assert property (req_valid_i && card_halted_flag_r
    && req_code_i != CLC_WAKE_REQ |=> !req_accept_o)
    else $error("halted card accepted other request");
a_rf_reset_clr: assert property (rf_reset_i && !halt_set_i
    |=> !card_halted_flag_r)
    else $error("rf reset left card halted");
a_resp_delay: assert property ($past(reset_n_i) |-> response_delay_o
    == CLC_RESP_BASE + {2'h0, $past(response_extra_delay)})
    else $error("response delay wrong");
a_reserved_zero: assert property (reg_rd_i && hit[CLC_IX_PASSIVE]
    |=> reg_rdata_o[5:0] == 6'h00)
    else $error("reserved bits read nonzero");
a_hold_select: assert property (hold_until_selected
    && !card_selected_i |=> !autocoll_done_o)
    else $error("anticollision ended before select");

endmodule : clc_link_config

// ===== tb/clc_rf_peer.sv
`timescale 1ns/1ps
module clc_rf_peer (
    input wire logic clk_sys_i,
    input wire logic rx_frame_discard_i,
    input wire logic req_accept_i,
    output logic rx_frame_end_o,
    output logic [7:0] rx_frame_bits_o,
    output logic signal_in_pin_o,
    output logic rf_level_o,
    output logic tx_last_pulse_o,
    output logic bit_clk_tick_o,
    output logic carrier_tick_o,
    output logic req_valid_o,
    output logic [7:0] req_code_o
);
    initial begin
        {rx_frame_end_o, signal_in_pin_o, rf_level_o, tx_last_pulse_o} = '0;
        {bit_clk_tick_o, carrier_tick_o, req_valid_o} = '0;
        rx_frame_bits_o = 8'h00;
        req_code_o = 8'h00;
    end
    // bit clock every other cycle, carrier every cycle
    always @(posedge clk_sys_i) begin
        bit_clk_tick_o <= ~bit_clk_tick_o;
        carrier_tick_o <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task frame(input logic [7:0] n, output logic d);
        @(posedge clk_sys_i);
        rx_frame_end_o <= 1'b1;
        rx_frame_bits_o <= n;
        @(posedge clk_sys_i);
        rx_frame_end_o <= 1'b0;
        // stale count shown inverted
        rx_frame_bits_o <= ~n;
        #1;
        d = rx_frame_discard_i;
    endtask : frame
    task request(input logic [7:0] c, output logic a);
        @(posedge clk_sys_i);
        req_valid_o <= 1'b1;
        req_code_o <= c;
        @(posedge clk_sys_i);
        req_valid_o <= 1'b0;
        req_code_o <= ~c;
        #1;
        a = req_accept_i;
    endtask : request
    task tx_done;
        @(posedge clk_sys_i);
        tx_last_pulse_o <= 1'b1;
        @(posedge clk_sys_i);
        tx_last_pulse_o <= 1'b0;
    endtask : tx_done
    task pins(input logic s, input logic r);
        @(posedge clk_sys_i);
        signal_in_pin_o <= s;
        rf_level_o <= r;
    endtask : pins
endmodule : clc_rf_peer

// ===== tb/contactless_link_config_regs_tb_top.sv
`timescale 1ns/1ps
module contactless_link_config_regs_tb_top;
import clc_pkg::*;
logic clk_sys_i, reset_n_i, reg_wr_i, reg_rd_i, tx_crc_enable_o;
logic [5:0] reg_addr_i;
logic [7:0] reg_wdata_i, reg_rdata_o, rx_frame_bits_i, req_code_i, d, w;
logic [2:0] tx_rate_sel_o, rx_rate_sel_o;
logic [1:0] tx_frame_format_o, rx_frame_format_o;
logic [3:0] decoder_strength_i, response_delay_o;
logic rx_crc_enable_o, rx_frame_end_i, rx_frame_discard_o, coder_env_i;
logic tx_serial_i, rx_serial_i, analog_mod_i, signal_in_pin_i, rf_level_i;
logic soft_power_down_i, antenna_driver_a_o, antenna_driver_a_oe_o;
logic antenna_driver_b_o, antenna_driver_b_oe_o, field_wake_o;
logic signal_out_pin_o, signal_out_pin_oe_o, cl_uart_in_o, tx_last_pulse_i;
logic bit_clk_tick_i, cmd_is_receive_i, rx_input_i, rx_enable_o, rx_bit_o;
logic carrier_tick_i, timer_tick_o, rx_receiving_i, pll_freeze_o, b, x;
logic autocoll_cmd_valid_i, card_selected_i, autocoll_done_o, req_valid_i;
logic active_comm_allowed_o, slot_half_o, halt_set_i, rf_reset_i;
logic req_accept_o;
int failures, num_checks, cyc, i, j, k, p, n;
localparam logic [3:0] SO_CODE [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h7};
// {oe, level} with coder 1, tx stream 0, rx stream 1
localparam logic [1:0] SO_EXP [6] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h2, 2'h3};
clc_link_config dut_u (.*);
clc_rf_peer peer_u (.clk_sys_i(clk_sys_i),
    .rx_frame_discard_i(rx_frame_discard_o), .req_accept_i(req_accept_o),
    .rx_frame_end_o(rx_frame_end_i), .rx_frame_bits_o(rx_frame_bits_i),
    .signal_in_pin_o(signal_in_pin_i), .rf_level_o(rf_level_i),
    .tx_last_pulse_o(tx_last_pulse_i), .bit_clk_tick_o(bit_clk_tick_i),
    .carrier_tick_o(carrier_tick_i), .req_valid_o(req_valid_i),
    .req_code_o(req_code_i));
////////////////////////////////////////////////////////////////////////////
task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
endtask : wr
task rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
endtask : rd
task st(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
endtask : st
task ck(input string nm, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
        failures++;
        $display("BAD %s exp %h got %h", nm, e, s);
    end
endtask : ck
task ac(input logic s, input logic e);
    @(posedge clk_sys_i);
    card_selected_i <= s;
    @(posedge clk_sys_i);
    autocoll_cmd_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    autocoll_cmd_valid_i <= 1'b0;
    #1;
    ck("done", autocoll_done_o, e);
endtask : ac
task gd(input logic r, output int c);
    @(posedge clk_sys_i);
    cmd_is_receive_i <= r;
    peer_u.tx_done();
    c = 0;
    repeat (40) begin
        @(posedge clk_sys_i);
        #1;
        c += !rx_enable_o;
    end
endtask : gd
task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask : results
initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
end
always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
        failures++;
        results();
    end
end
////////////////////////////////////////////////////////////////////////////
initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {coder_env_i, tx_serial_i, analog_mod_i, soft_power_down_i} = '0;
    {cmd_is_receive_i, rx_receiving_i, card_selected_i, halt_set_i} = '0;
    {autocoll_cmd_valid_i, rf_reset_i} = '0;
    {rx_serial_i, rx_input_i, decoder_strength_i} = '1;
    {failures, num_checks, cyc} = '0;
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < CLC_NREG; i++) begin
        rd(CLC_OFS[i], d);
        ck("reset", d, CLC_RESET[i]);
    end
    rd(6'h1a, d);
    ck("unmapped", d, 8'h00);
    ck("resp", response_delay_o, 4'h9);
    for (i = 0; i < CLC_NREG; i++) wr(CLC_OFS[i], 8'hff ^ 8'((i == 9) * 4));
    for (i = 0; i < CLC_NREG; i++) begin
        rd(CLC_OFS[i], d);
        ck("mask", d, CLC_MASK[i]);
    end
    ck("rate", {tx_rate_sel_o, rx_rate_sel_o}, 6'h12);
    for (i = 0; i < CLC_NREG; i++) wr(CLC_OFS[i], CLC_RESET[i]);
    $display("test registers done");
    for (i = 0; i < 3; i++) for (j = 0; j < 3; j += 2) begin
        w = {i != 0, i[2:0], 2'h0, j[1:0]};
        wr(CLC_OFS_TX_MODE, w);
        wr(CLC_OFS_RX_MODE, w);
        st(3);
        ck("tx", {tx_crc_enable_o, tx_rate_sel_o, tx_frame_format_o},
            {w[7:4], w[1:0]});
        ck("rx", {rx_crc_enable_o, rx_rate_sel_o, rx_frame_format_o},
            {w[7:4], w[1:0]});
    end
    wr(CLC_OFS_PASSIVE, 8'h40);
    st(3);
    ck("slot", slot_half_o, 1'b1);
    wr(CLC_OFS_TX_MODE, 8'h90);
    st(3);
    ck("slot", slot_half_o, 1'b0);
    wr(CLC_OFS_PASSIVE, 8'h80);
    st(3);
    ck("active", active_comm_allowed_o, 1'b0);
    ac(1'b0, 1'b0);
    ac(1'b1, 1'b1);
    wr(CLC_OFS_PASSIVE, 8'h00);
    wr(CLC_OFS_RX_MODE, 8'h08);
    peer_u.frame(8'd3, b);
    ck("drop", b, 1'b1);
    peer_u.frame(8'd4, b);
    ck("drop", {b, rx_enable_o}, 2'h1);
    wr(CLC_OFS_RX_MODE, 8'h00);
    peer_u.frame(8'd3, b);
    ck("drop", b, 1'b0);
    $display("test modes done");
    for (p = 0; p < 2; p++) for (k = 0; k < 2; k++) for (i = 0; i < 4; i++)
    for (j = 0; j < 2; j++) begin
        peer_u.pins(!p, 1'b0);
        coder_env_i <= p[0];
        soft_power_down_i <= k[0];
        wr(CLC_OFS_DRV_CTRL, {2'h2, j[0], j[0], 4'h0});
        wr(CLC_OFS_SRC_SEL, {2'h0, i[1:0], 4'h0});
        st(6);
        x = ((i == 1) ? p[0] : (i == 2) ? !p : 1'b1) ^ j[0];
        ck("drv", {antenna_driver_a_oe_o, antenna_driver_b_oe_o,
            (i != 0) && antenna_driver_a_o, (i != 0) && antenna_driver_b_o},
            {i != 0, i != 0, x && i != 0, x && i != 0});
    end
    @(posedge clk_sys_i);
    soft_power_down_i <= 1'b0;
    for (i = 0; i < 6; i++) begin
        wr(CLC_OFS_SRC_SEL, {4'h1, SO_CODE[i]});
        st(3);
        ck("signal_out_pin", {signal_out_pin_oe_o,
            signal_out_pin_oe_o && signal_out_pin_o}, SO_EXP[i]);
    end
    for (p = 0; p < 2; p++) for (i = 0; i < 4; i++) begin
        peer_u.pins(p[0], 1'b0);
        analog_mod_i <= !p;
        wr(CLC_OFS_RX_SEL, {i[1:0], 6'h04});
        st(6);
        x = (i == 0) ? 1'b0 : (i == 2) ? !p : p[0];
        ck("uart", cl_uart_in_o, x);
    end
    $display("test selectors done");
    gd(1'b0, n);
    ck("guard", n == 6 || n == 7, 1'b1);
    gd(1'b1, n);
    ck("guard", n, 16'h0);
    @(posedge clk_sys_i);
    decoder_strength_i <= 4'h7;
    rx_receiving_i <= 1'b1;
    st(3);
    ck("minlvl", {rx_bit_o, pll_freeze_o}, 2'h0);
    @(posedge clk_sys_i);
    decoder_strength_i <= 4'h8;
    wr(CLC_OFS_DEMOD, 8'h41);
    st(3);
    ck("minlvl", {rx_bit_o, pll_freeze_o}, 2'h3);
    for (k = 0; k < 2; k++) begin
        wr(CLC_OFS_DEMOD, {3'h2, k[0], 4'h1});
        st(3);
        n = 0;
        repeat (20) begin
            @(posedge clk_sys_i);
            #1;
            n += timer_tick_o;
        end
        ck("timer", n, 16'(20 / (k + 1)));
    end
    @(posedge clk_sys_i);
    halt_set_i <= 1'b1;
    @(posedge clk_sys_i);
    halt_set_i <= 1'b0;
    peer_u.request(8'h26, b);
    ck("accept", b, 1'b0);
    peer_u.request(8'h52, b);
    rd(CLC_OFS_CARD, d);
    ck("halted", {b, d[2]}, 2'h3);
    @(posedge clk_sys_i);
    rf_reset_i <= 1'b1;
    @(posedge clk_sys_i);
    rf_reset_i <= 1'b0;
    peer_u.request(8'h26, b);
    rd(CLC_OFS_CARD, d);
    ck("halted", {b, d[2]}, 2'h2);
    wr(CLC_OFS_CARD, 8'h63);
    st(3);
    ck("resp", response_delay_o, 4'ha);
    wr(CLC_OFS_CARD, 8'h60);
    st(3);
    ck("resp", response_delay_o, 4'h7);
    wr(CLC_OFS_AUTO_WAKE, 8'h20);
    soft_power_down_i <= 1'b1;
    for (k = 1; k >= 0; k--) begin
        peer_u.pins(1'b0, k[0]);
        st(7);
        ck("wake", field_wake_o, k[0]);
    end
    $display("test receive side done");
    results();
end
endmodule : contactless_link_config_regs_tb_top
